//--- src/dum_pkg.sv
// dum_pkg: constants shared by the serial port block and its channel module.
// assumes a 40 MHz system clock; no software registers exist.
package dum_pkg;

  // ****************************************
  // clock and baud timing
  // ****************************************
  localparam int unsigned CLK_HZ        = 40000000;
  localparam int unsigned MAX_BAUD_BPS  = 921000;   // fastest rate either port must carry
  // divider value for the fastest rate; software-free, so divider is a port
  localparam logic [15:0] MIN_DIV       = 16'(CLK_HZ / MAX_BAUD_BPS);
  localparam logic [15:0] RESET_DIV     = 16'h0015; // 21 clocks per bit, about 1.9 Mbit/s at reset
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned BUF_DEPTH     = 2;

  // ****************************************
  // wire configurations of a port
  // ****************************************
  localparam logic [1:0] CFG_7WIRE = 2'h0;
  localparam logic [1:0] CFG_5WIRE = 2'h1;
  localparam logic [1:0] CFG_4WIRE = 2'h2;
  localparam logic [1:0] CFG_2WIRE = 2'h3;

  // ****************************************
  // frame format fields
  // ****************************************
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_ODD  = 2'h2;

  typedef enum logic [2:0] {
    DUM_IDLE,
    DUM_START,
    DUM_DATA,
    DUM_PARITY,
    DUM_STOP
  } dum_state_t;

endpackage : dum_pkg

//--- src/dum_channel.sv
// dum_channel: one serial channel, transmit toward host and receive from host.
// assumes line inputs are already synchronised; baud divider is the clock count per bit.
`timescale 1ns/1ps
`default_nettype none
module dum_channel
  import dum_pkg::*;
(
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // configuration
  input  wire logic [15:0]       baud_div,
  input  wire logic [1:0]        parity_mode,
  input  wire logic              two_stop,
  input  wire logic              tx_allowed,
  // outgoing characters toward the host
  input  wire logic              out_valid,
  output logic                   out_ready,
  input  wire logic [DATA_W-1:0] out_data,
  // incoming characters from the host
  output logic                   in_valid,
  input  wire logic              in_ready,
  output logic [DATA_W-1:0]      in_data,
  output logic                   in_err_q,
  output logic                   in_space,
  // serial lines
  output logic                   line_out_q,
  input  wire logic              line_in_s
);

  // ****************************************
  // transmitter
  // ****************************************
  dum_state_t         tx_st_q;
  logic [15:0]        tx_cnt_q;
  logic [2:0]         tx_bit_q;
  logic [DATA_W-1:0]  tx_sh_q;
  logic               tx_par_q;
  logic               tx_stop2_q;

  // a new character only starts in idle with permission
  assign out_ready = (tx_st_q == DUM_IDLE) && tx_allowed;

  // one bit period per count run; lsb first, line idles high
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_st_q    <= DUM_IDLE;
      tx_cnt_q   <= 16'h0000;
      tx_bit_q   <= 3'h0;
      tx_sh_q    <= '0;
      tx_par_q   <= 1'b0;
      tx_stop2_q <= 1'b0;
      line_out_q <= 1'b1;
    end else if (tx_st_q == DUM_IDLE) begin
      line_out_q <= 1'b1;
      if (out_valid && out_ready) begin
        tx_st_q    <= DUM_START;
        tx_sh_q    <= out_data;
        tx_par_q   <= (parity_mode == PAR_ODD) ^ (^out_data);
        tx_cnt_q   <= baud_div;
        tx_bit_q   <= 3'h0;
        tx_stop2_q <= two_stop;
        line_out_q <= 1'b0;            // start bit
      end
    end else if (tx_cnt_q > 16'h0001) begin
      tx_cnt_q <= tx_cnt_q - 16'h0001;
    end else begin
      tx_cnt_q <= baud_div;
      case (tx_st_q)
        DUM_START: begin
          tx_st_q    <= DUM_DATA;
          line_out_q <= tx_sh_q[0];
        end
        DUM_DATA: begin
          if (tx_bit_q == 3'h7) begin
            tx_st_q    <= (parity_mode == PAR_NONE) ? DUM_STOP : DUM_PARITY;
            line_out_q <= (parity_mode == PAR_NONE) ? 1'b1 : tx_par_q;
          end else begin
            tx_bit_q   <= tx_bit_q + 3'h1;
            line_out_q <= tx_sh_q[tx_bit_q + 3'h1];
          end
        end
        DUM_PARITY: begin
          tx_st_q    <= DUM_STOP;
          line_out_q <= 1'b1;
        end
        DUM_STOP: begin
          line_out_q <= 1'b1;
          if (tx_stop2_q) begin
            tx_stop2_q <= 1'b0;        // second stop bit
          end else begin
            tx_st_q <= DUM_IDLE;
          end
        end
        default: begin
          tx_st_q    <= DUM_IDLE;
          line_out_q <= 1'b1;
        end
      endcase
    end
  end

  // ****************************************
  // receiver
  // ****************************************
  dum_state_t         rx_st_q;
  logic [15:0]        rx_cnt_q;
  logic [2:0]         rx_bit_q;
  logic [DATA_W-1:0]  rx_sh_q;
  logic               rx_done_q;
  logic               rx_bad_q;
  logic               rx_ok;
  logic               buf_full;

  // samples land mid-bit: half period after the falling edge, then whole periods
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_st_q   <= DUM_IDLE;
      rx_cnt_q  <= 16'h0000;
      rx_bit_q  <= 3'h0;
      rx_sh_q   <= '0;
      rx_done_q <= 1'b0;
      rx_bad_q  <= 1'b0;
    end else begin
      rx_done_q <= 1'b0;
      if (rx_st_q == DUM_IDLE) begin
        if (!line_in_s) begin
          rx_st_q  <= DUM_START;
          rx_cnt_q <= {1'b0, baud_div[15:1]};
          rx_bad_q <= 1'b0;
        end
      end else if (rx_cnt_q > 16'h0001) begin
        rx_cnt_q <= rx_cnt_q - 16'h0001;
      end else begin
        rx_cnt_q <= baud_div;
        case (rx_st_q)
          DUM_START: begin
            // a glitch shorter than half a bit is not a start bit
            rx_st_q  <= line_in_s ? DUM_IDLE : DUM_DATA;
            rx_bit_q <= 3'h0;
          end
          DUM_DATA: begin
            rx_sh_q <= {line_in_s, rx_sh_q[DATA_W-1:1]};
            if (rx_bit_q == 3'h7) begin
              rx_st_q <= (parity_mode == PAR_NONE) ? DUM_STOP : DUM_PARITY;
            end
            rx_bit_q <= rx_bit_q + 3'h1;
          end
          DUM_PARITY: begin
            rx_bad_q <= line_in_s ^ (parity_mode == PAR_ODD) ^ (^rx_sh_q);
            rx_st_q  <= DUM_STOP;
          end
          DUM_STOP: begin
            // framing error when the stop bit is low
            rx_bad_q  <= rx_bad_q | !line_in_s;
            rx_done_q <= 1'b1;
            rx_st_q   <= DUM_IDLE;
          end
          default: rx_st_q <= DUM_IDLE;
        endcase
      end
    end
  end

  // sticky error, set wins over clear when a bad char arrives as the next is taken
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      in_err_q <= 1'b0;
    end else if (rx_done_q && rx_bad_q) begin
      in_err_q <= 1'b1;
    end else if (in_valid && in_ready) begin
      in_err_q <= 1'b0;
    end
  end

  // ****************************************
  // two-entry receive buffer
  // ****************************************
  logic [DATA_W-1:0]  buf_mem_q [BUF_DEPTH];
  logic               buf_wp_q;
  logic               buf_rp_q;
  logic [1:0]         buf_cnt_q;

  assign buf_full = (buf_cnt_q == 2'h2);
  assign rx_ok    = rx_done_q && !buf_full;   // overrun drops the word
  assign in_valid = (buf_cnt_q != 2'h0);
  assign in_data  = buf_mem_q[buf_rp_q];
  // grant withdrawn while any character waits in the buffer
  assign in_space = (buf_cnt_q == 2'h0);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      buf_wp_q  <= 1'b0;
      buf_rp_q  <= 1'b0;
      buf_cnt_q <= 2'h0;
      for (int i = 0; i < BUF_DEPTH; i++) begin
        buf_mem_q[i] <= '0;
      end
    end else begin
      if (rx_ok) begin
        buf_mem_q[buf_wp_q] <= rx_sh_q;
        buf_wp_q            <= !buf_wp_q;
      end
      if (in_valid && in_ready) begin
        buf_rp_q <= !buf_rp_q;
      end
      buf_cnt_q <= buf_cnt_q + {1'b0, rx_ok} - {1'b0, in_valid && in_ready};
    end
  end

endmodule : dum_channel
`default_nettype wire

//--- src/dum_serial_ports.sv
// dum_serial_ports: main and auxiliary serial ports of the device, DCE side.
// assumes host-side pins arrive asynchronously; configuration inputs are static.
//
// Functional notes
// - main port acts as dce with two data lines and five handshake lines
// - main port runs at rates up to 921 kbit/s
// - data from host arrives on tx line, data to host leaves on rx line
// - device drives grant, carrier, ring; senses request and ready; all active low
// - both ports use request/grant flow control in normal operation
// - two-wire main port: flow control off, host holds ready and request low
// - unused handshake lines and shared pin functions unavailable in reduced configs
// - aux port up to 921 kbit/s with data, request and grant only
// - aux port only on variants without positioning; else two pins are gpio
// - aux two-wire: partner flows itself, flow control off, request low
`timescale 1ns/1ps
`default_nettype none
module dum_serial_ports
  import dum_pkg::*;
(
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // main port configuration
  input  wire logic [1:0]        main_wire_cfg,
  input  wire logic [15:0]       main_baud_div,
  input  wire logic [1:0]        main_parity,
  input  wire logic              main_two_stop,
  input  wire logic              main_flow_en,
  // main port status drive from firmware
  input  wire logic              main_carrier_on,
  input  wire logic              main_ring_on,
  // main port character streams
  input  wire logic              main_out_valid,
  output logic                   main_out_ready,
  input  wire logic [DATA_W-1:0] main_out_data,
  output logic                   main_in_valid,
  input  wire logic              main_in_ready,
  output logic [DATA_W-1:0]      main_in_data,
  output logic                   main_in_err,
  output logic                   main_terminal_active,
  // main port pins
  input  wire logic              main_host_tx_data,
  output logic                   main_host_rx_data,
  input  wire logic              main_host_send_request_n,
  output logic                   main_dev_send_grant_n,
  output logic                   main_dev_send_grant_oe,
  input  wire logic              main_terminal_ready_n,
  output logic                   main_carrier_detect_n,
  output logic                   main_carrier_detect_oe,
  output logic                   main_ring_indicate_n,
  output logic                   main_ring_indicate_oe,
  // aux port configuration
  input  wire logic              aux_present,
  input  wire logic              aux_two_wire,
  input  wire logic [15:0]       aux_baud_div,
  input  wire logic [1:0]        aux_parity,
  input  wire logic              aux_two_stop,
  input  wire logic              aux_flow_en,
  // aux port character streams
  input  wire logic              aux_out_valid,
  output logic                   aux_out_ready,
  input  wire logic [DATA_W-1:0] aux_out_data,
  output logic                   aux_in_valid,
  input  wire logic              aux_in_ready,
  output logic [DATA_W-1:0]      aux_in_data,
  output logic                   aux_in_err,
  // aux port pins
  input  wire logic              aux_host_tx_data,
  output logic                   aux_host_rx_data,
  output logic                   aux_host_rx_oe,
  input  wire logic              aux_host_send_request_n,
  output logic                   aux_dev_send_grant_n,
  output logic                   aux_dev_send_grant_oe
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  localparam int unsigned NSYNC = 5;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;

  // idle of each line is high, so both stages reset high
  assign pin_raw = {aux_host_send_request_n, aux_host_tx_data, main_terminal_ready_n,
                    main_host_send_request_n, main_host_tx_data};

  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : g_sync
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          sync1_q[g] <= 1'b1;
          sync2_q[g] <= 1'b1;
        end else begin
          sync1_q[g] <= pin_raw[g];
          sync2_q[g] <= sync1_q[g];
        end
      end
    end
  endgenerate

  // ****************************************
  // main port handshake policy
  // ****************************************
  logic main_fc;
  logic main_allow;
  logic main_space;
  logic main_rx_line;
  logic aux_fc;
  logic aux_allow;
  logic aux_space;
  logic aux_rx_line;
  logic aux_line_in;

  // two-wire forbids hardware flow control, partner paces itself
  assign main_fc    = main_flow_en && (main_wire_cfg != CFG_2WIRE);
  // request sensed active low, gates new characters only
  assign main_allow = !main_fc || !sync2_q[1];
  // terminal-ready sensed only where the config carries it
  assign main_terminal_active = (main_wire_cfg != CFG_4WIRE) && (main_wire_cfg != CFG_2WIRE)
                                && !sync2_q[2];

  // outputs of unused lines released so the shared pins can go elsewhere
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      main_dev_send_grant_n  <= 1'b1;
      main_dev_send_grant_oe <= 1'b0;
      main_carrier_detect_n  <= 1'b1;
      main_carrier_detect_oe <= 1'b0;
      main_ring_indicate_n   <= 1'b1;
      main_ring_indicate_oe  <= 1'b0;
    end else begin
      main_dev_send_grant_n  <= !(main_space || !main_fc);
      main_dev_send_grant_oe <= (main_wire_cfg != CFG_2WIRE);
      main_carrier_detect_n  <= !main_carrier_on;
      main_carrier_detect_oe <= (main_wire_cfg == CFG_7WIRE);
      main_ring_indicate_n   <= !main_ring_on;
      main_ring_indicate_oe  <= (main_wire_cfg == CFG_7WIRE);
    end
  end

  // ****************************************
  // main channel
  // ****************************************
  // divider is floored at the fastest supported rate
  dum_channel u_main (
    .clock       (clock),
    .rst         (rst),
    .baud_div    ((main_baud_div < MIN_DIV) ? MIN_DIV : main_baud_div),
    .parity_mode (main_parity),
    .two_stop    (main_two_stop),
    .tx_allowed  (main_allow),
    .out_valid   (main_out_valid),
    .out_ready   (main_out_ready),
    .out_data    (main_out_data),
    .in_valid    (main_in_valid),
    .in_ready    (main_in_ready),
    .in_data     (main_in_data),
    .in_err_q    (main_in_err),
    .in_space    (main_space),
    .line_out_q  (main_rx_line),
    .line_in_s   (sync2_q[0])
  );
  assign main_host_rx_data = main_rx_line;

  // ****************************************
  // aux port
  // ****************************************
  // without the aux function its pins belong to gpio: all drives off
  assign aux_fc      = aux_present && aux_flow_en && !aux_two_wire;
  assign aux_allow   = aux_present && (!aux_fc || !sync2_q[4]);
  assign aux_line_in = aux_present ? sync2_q[3] : 1'b1;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      aux_dev_send_grant_n  <= 1'b1;
      aux_dev_send_grant_oe <= 1'b0;
      aux_host_rx_oe        <= 1'b0;
    end else begin
      aux_dev_send_grant_n  <= !(aux_space || !aux_fc);
      aux_dev_send_grant_oe <= aux_present && !aux_two_wire;
      aux_host_rx_oe        <= aux_present;
    end
  end

  dum_channel u_aux (
    .clock       (clock),
    .rst         (rst),
    .baud_div    ((aux_baud_div < MIN_DIV) ? MIN_DIV : aux_baud_div),
    .parity_mode (aux_parity),
    .two_stop    (aux_two_stop),
    .tx_allowed  (aux_allow),
    .out_valid   (aux_out_valid),
    .out_ready   (aux_out_ready),
    .out_data    (aux_out_data),
    .in_valid    (aux_in_valid),
    .in_ready    (aux_in_ready),
    .in_data     (aux_in_data),
    .in_err_q    (aux_in_err),
    .in_space    (aux_space),
    .line_out_q  (aux_rx_line),
    .line_in_s   (aux_line_in)
  );
  assign aux_host_rx_data = aux_rx_line;

endmodule : dum_serial_ports
`default_nettype wire

//--- tb/dum_host_model.sv
// host model for the main port: sends framed chars, decodes the device's chars.
// assumes BIT_CLKS clocks per bit; replies carry no parity.
`timescale 1ns/1ps
`default_nettype none
module dum_host_model #(
  parameter int BIT_CLKS = 43
) (
  // clock
  input  wire logic clock,
  // serial lines and request
  output var  logic host_tx,
  input  wire logic host_rx,
  output var  logic request_n
);
  logic [7:0] rx_q[$];
  logic [7:0] shift;
  logic       rx_bad;

  // ************
  // transmitter
  // ************
  // idle high, request on so the device may send
  initial begin
    host_tx = 1'h1;
    request_n = 1'h0;
    rx_bad = 1'h0;
  end

  // start, data lsb first, optional even parity, stop
  task automatic send(input logic [7:0] b, input logic par);
    logic [10:0] f;
    f = {1'h1, ^b, b, 1'h0};
    for (int i = 0; i < 11; i++) begin
      if (i != 9 || par) begin
        @(posedge clock);
        host_tx <= f[i];
        repeat (BIT_CLKS - 1) @(posedge clock);
      end
    end
  endtask : send

  // ************
  // receiver
  // ************
  // mid-bit sampling; a low stop bit marks the run bad
  initial begin
    forever begin
      @(posedge clock);
      if (host_rx === 1'h0) begin
        repeat (BIT_CLKS / 2) @(posedge clock);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_CLKS) @(posedge clock);
          shift[i] = host_rx;
        end
        repeat (BIT_CLKS) @(posedge clock);
        if (host_rx !== 1'h1) rx_bad = 1'h1;
        rx_q.push_back(shift);
      end
    end
  end
endmodule : dum_host_model
`default_nettype wire

//--- tb/dum_serial_ports_assertions.sv
// checker for the serial port block: pin enables, flow control, framing start.
// bound to dum_serial_ports; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module dum_serial_ports_assertions
  import dum_pkg::*;
(
  // clock and reset
  input wire logic       clock,
  input wire logic       rst,
  // configuration
  input wire logic [1:0] main_wire_cfg,
  input wire logic       main_flow_en,
  input wire logic       main_carrier_on,
  input wire logic       aux_present,
  // streams
  input wire logic       main_out_valid,
  input wire logic       main_out_ready,
  input wire logic       main_in_valid,
  // pins
  input wire logic       main_host_rx_data,
  input wire logic       main_host_send_request_n,
  input wire logic       main_dev_send_grant_n,
  input wire logic       main_dev_send_grant_oe,
  input wire logic       main_terminal_ready_n,
  input wire logic       main_terminal_active,
  input wire logic       main_carrier_detect_n,
  input wire logic       main_carrier_detect_oe,
  input wire logic       aux_host_rx_oe
);
  // ************
  // properties
  // ************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // registered enables lag the config by one edge
  sequence s_cfg_settled; !$past(rst) && $stable(main_wire_cfg); endsequence
  sequence s_take; main_out_valid && main_out_ready; endsequence
  sequence s_start_bit; (!main_host_rx_data && !main_out_ready) [*8]; endsequence

  property p_grant_oe; s_cfg_settled |-> main_dev_send_grant_oe == (main_wire_cfg != CFG_2WIRE); endproperty
  a_grant_oe: assert property (p_grant_oe) else $error("grant enable wrong");
  property p_carrier_oe; s_cfg_settled |-> main_carrier_detect_oe == (main_wire_cfg == CFG_7WIRE); endproperty
  a_carrier_oe: assert property (p_carrier_oe) else $error("carrier enable wrong");
  property p_aux_oe; !$past(rst) && $stable(aux_present) |-> aux_host_rx_oe == aux_present; endproperty
  a_aux_oe: assert property (p_aux_oe) else $error("aux rx enable wrong");

  // four edges cover the request synchroniser
  property p_req_gate;
    (main_flow_en && main_wire_cfg != CFG_2WIRE && main_host_send_request_n) [*4] |-> !main_out_ready;
  endproperty
  a_req_gate: assert property (p_req_gate) else $error("send not held off");
  property p_start; s_take |=> s_start_bit; endproperty
  a_start: assert property (p_start) else $error("no start bit after take");

  property p_carrier;
    !$past(rst) && $stable(main_wire_cfg) && $stable(main_carrier_on) && main_wire_cfg == CFG_7WIRE
      |-> main_carrier_detect_n == !main_carrier_on;
  endproperty
  a_carrier: assert property (p_carrier) else $error("carrier level wrong");
  property p_terminal; (!main_terminal_ready_n && main_wire_cfg <= CFG_5WIRE) [*3] |-> main_terminal_active;
  endproperty
  a_terminal: assert property (p_terminal) else $error("terminal ready missed");
  property p_term_off; main_wire_cfg == CFG_4WIRE |-> !main_terminal_active; endproperty
  a_term_off: assert property (p_term_off) else $error("terminal ready used");
  property p_grant_full; (main_in_valid && main_flow_en && main_wire_cfg != CFG_2WIRE) [*2] |-> main_dev_send_grant_n;
  endproperty
  a_grant_full: assert property (p_grant_full) else $error("grant kept while buffered");
endmodule : dum_serial_ports_assertions
`default_nettype wire

//--- tb/tb_top.sv
// testbench for the serial ports: host model on main, aux looped on itself.
// config inputs change only while neither port is receiving a character.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dum_pkg::*;
  // ************
  // design pins
  // ************
  logic clock = 1'h0, rst = 1'h1, main_two_stop = 1'h0, main_flow_en = 1'h1, main_carrier_on = 1'h0;
  logic main_ring_on = 1'h0, main_out_valid = 1'h0, main_in_ready = 1'h0, main_terminal_ready_n = 1'h1;
  logic aux_present = 1'h1, aux_two_wire = 1'h0, aux_two_stop = 1'h1, aux_flow_en = 1'h1, aux_out_valid = 1'h0;
  logic aux_in_ready = 1'h0, aux_host_tx_data = 1'h1, aux_host_send_request_n = 1'h0;
  logic [1:0] main_wire_cfg = CFG_7WIRE, main_parity = PAR_NONE, aux_parity = PAR_ODD;
  logic [7:0] main_out_data = 8'h00, aux_out_data = 8'h00, main_in_data, aux_in_data;
  logic [15:0] main_baud_div = 16'h0010, aux_baud_div = MIN_DIV;
  logic main_host_tx_data, main_host_send_request_n, main_out_ready, main_in_valid, main_in_err;
  logic main_terminal_active, main_host_rx_data, main_dev_send_grant_n, main_dev_send_grant_oe;
  logic main_carrier_detect_n, main_carrier_detect_oe, main_ring_indicate_n, main_ring_indicate_oe;
  logic aux_out_ready, aux_in_valid, aux_in_err, aux_host_rx_data, aux_host_rx_oe;
  logic aux_dev_send_grant_n, aux_dev_send_grant_oe;
  int fails = 0, tests_run = 0;

  dum_serial_ports dut (.*);
  // divider below the floor is raised, so the host runs at the floor
  dum_host_model #(.BIT_CLKS(int'(MIN_DIV))) host (
    .clock    (clock),
    .host_tx  (main_host_tx_data),
    .host_rx  (main_host_rx_data),
    .request_n(main_host_send_request_n)
  );
  // clock, and aux port talking to itself
  always #12.5 clock = ~clock;
  always @(posedge clock) aux_host_tx_data <= aux_host_rx_data;

  // ************
  // shared tasks
  // ************
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic put_main(input logic [7:0] b);
    int n;
    @(posedge clock);
    main_out_data <= b;
    main_out_valid <= 1'h1;
    @(posedge clock);
    for (n = 0; n < 3000 && main_out_ready !== 1'h1; n++) @(posedge clock);
    main_out_valid <= 1'h0;
  endtask : put_main

  task automatic take_main(input logic [7:0] exp, input logic err);
    int n;
    @(posedge clock);
    for (n = 0; n < 3000 && main_in_valid !== 1'h1; n++) @(posedge clock);
    @(posedge clock);
    check("in_data", exp, main_in_data);
    check("in_err", err, main_in_err);
    main_in_ready <= 1'h1;
    @(posedge clock);
    main_in_ready <= 1'h0;
  endtask : take_main

  task automatic wait_host(input int k);
    for (int n = 0; n < 3000 && host.rx_q.size() < k; n++) @(posedge clock);
  endtask : wait_host

  // ************
  // scenarios
  // ************
  task automatic t_reset();
    repeat (7) @(posedge clock);
    check("rx_idle_in_reset", 1, main_host_rx_data);
    check("grant_oe_in_reset", 0, main_dev_send_grant_oe);
    @(posedge clock);
    rst <= 1'h0;
    repeat (3) @(posedge clock);
    check("status_oe_7wire", 3, {main_carrier_detect_oe, main_ring_indicate_oe});
    check("aux_rx_oe", 1, aux_host_rx_oe);
  endtask : t_reset

  task automatic t_send();
    put_main(8'hA5);
    put_main(8'h3C);
    wait_host(2);
    check("host_rx_first", 8'hA5, host.rx_q.pop_front());
    check("host_rx_second", 8'h3C, host.rx_q.pop_front());
  endtask : t_send

  task automatic t_flow();
    host.request_n <= 1'h1;
    repeat (4) @(posedge clock);
    fork
      put_main(8'h5A);
      begin
        repeat (100) @(posedge clock);
        check("no_char_sent", 0, host.rx_q.size());
        host.request_n <= 1'h0;
      end
    join
    wait_host(1);
    check("char_after_request", 8'h5A, host.rx_q.pop_front());
  endtask : t_flow

  task automatic t_recv();
    int n;
    host.send(8'hC3, 1'h0);
    for (n = 0; n < 3000 && main_in_valid !== 1'h1; n++) @(posedge clock);
    repeat (2) @(posedge clock);
    check("grant_withdrawn", 1, main_dev_send_grant_n);
    host.send(8'h81, 1'h0);
    take_main(8'hC3, 1'h0);
    take_main(8'h81, 1'h0);
    repeat (3) @(posedge clock);
    check("grant_restored", 0, main_dev_send_grant_n);
    main_parity <= PAR_EVEN;
    host.send(8'h96, 1'h1);
    take_main(8'h96, 1'h0);
    main_parity <= PAR_ODD;
    host.send(8'h96, 1'h1);
    take_main(8'h96, 1'h1);
    main_parity <= PAR_NONE;
  endtask : t_recv

  task automatic t_status();
    main_terminal_ready_n <= 1'h0;
    main_wire_cfg <= CFG_5WIRE;
    repeat (4) @(posedge clock);
    check("terminal_active_5wire", 1, main_terminal_active);
    check("status_oe_5wire", 0, {main_carrier_detect_oe, main_ring_indicate_oe});
    main_wire_cfg <= CFG_4WIRE;
    repeat (3) @(posedge clock);
    check("terminal_ignored_4wire", 0, main_terminal_active);
    main_wire_cfg <= CFG_7WIRE;
    for (int i = 0; i < 2; i++) begin
      main_carrier_on <= i[0];
      main_ring_on <= !i[0];
      repeat (3) @(posedge clock);
      check("carrier_ring_n", {!i[0], i[0]}, {main_carrier_detect_n, main_ring_indicate_n});
    end
  endtask : t_status

  // host breaks its hold-low duty to prove the request is ignored
  task automatic t_two_wire();
    main_wire_cfg <= CFG_2WIRE;
    main_baud_div <= MIN_DIV;
    main_two_stop <= 1'h1;
    host.request_n <= 1'h1;
    repeat (4) @(posedge clock);
    check("grant_oe_2wire", 0, main_dev_send_grant_oe);
    check("ready_ignores_request", 1, main_out_ready);
    put_main(8'h0F);
    wait_host(1);
    check("two_wire_char", 8'h0F, host.rx_q.pop_front());
    main_wire_cfg <= CFG_7WIRE;
    main_flow_en <= 1'h0;
    repeat (80) @(posedge clock);
    check("ready_flow_off", 1, main_out_ready);
    host.request_n <= 1'h0;
    main_flow_en <= 1'h1;
  endtask : t_two_wire

  task automatic t_aux();
    int n;
    check("aux_grant", 1, {aux_dev_send_grant_n, aux_dev_send_grant_oe});
    aux_in_ready <= 1'h1;
    aux_out_data <= 8'h6B;
    aux_out_valid <= 1'h1;
    @(posedge clock);
    for (n = 0; n < 3000 && aux_out_ready !== 1'h1; n++) @(posedge clock);
    aux_out_valid <= 1'h0;
    for (n = 0; n < 3000 && aux_in_valid !== 1'h1; n++) @(posedge clock);
    check("aux_loop_data", 8'h6B, aux_in_data);
    check("aux_loop_err", 0, aux_in_err);
    aux_two_wire <= 1'h1;
    aux_flow_en <= 1'h0;
    repeat (3) @(posedge clock);
    check("aux_grant_oe_2wire", 0, aux_dev_send_grant_oe);
    aux_present <= 1'h0;
    repeat (3) @(posedge clock);
    check("aux_rx_oe_absent", 0, aux_host_rx_oe);
  endtask : t_aux

  task automatic final_report();
    if (fails == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  // main sequence
  initial begin
    t_reset();
    t_send();
    t_flow();
    t_recv();
    t_status();
    t_two_wire();
    t_aux();
    check("host_frames_ok", 0, host.rx_bad);
    final_report();
  end
  // watchdog: the run needs about 4200 clocks
  initial begin
    repeat (40000) @(posedge clock);
    fails++;
    final_report();
  end
endmodule : tb_top

bind dum_serial_ports dum_serial_ports_assertions chk (.*);
`default_nettype wire
